// [design/eiu_external_interface_unit.sv]
// External interface unit: chip selects, bus sizing, boot select and watchdog
`timescale 1ns/10ps
`default_nettype none
module eiu_external_interface_unit
    import eiu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    // Core bus
    input wire logic core_req,
    input wire logic core_write,
    input wire logic [31:0] core_addr,
    input wire logic [eiu_pkg::NUM_CS*2-1:0] core_size_unused,
    input wire logic [1:0] core_size,
    input wire logic [31:0] core_wdata,
    output logic [31:0] core_rdata,
    output logic transfer_ack,
    output logic transfer_error_ack,
    output logic [1:0] transfer_size_code,
    // Per-select configuration
    input wire logic [eiu_pkg::NUM_CS-1:0] cs_enable,
    input wire logic [eiu_pkg::NUM_CS-1:0] cs_gpo_level,
    input wire logic [eiu_pkg::NUM_CS*4-1:0] cs_wait_states,
    input wire logic [eiu_pkg::NUM_CS*2-1:0] port_size_field,
    input wire logic cfg_valid,
    // Boot control
    input wire logic boot_select,
    input wire logic reset_out_n,
    output logic int_rom_enable,
    output logic [31:0] reset_vector,
    // External pins
    output logic [eiu_pkg::ADDR_W-1:0] ext_address_lines,
    input wire logic [eiu_pkg::DATA_W-1:0] ext_data_in,
    output logic [eiu_pkg::DATA_W-1:0] ext_data_out,
    output logic ext_data_oe,
    output logic rd_wr,
    output logic byte_lane_enable_upper_n,
    output logic byte_lane_enable_lower_n,
    output logic out_enable_n,
    output logic chip_select_zero_n,
    output logic [3:0] chip_selects_one_to_four_n,
    output logic chip_select_five_high
);
    import eiu_pkg::*;

    eiu_state_t state_q;
    logic [7:0] wdog_q;
    logic [4:0] wait_q;
    logic [1:0] beat_q;
    logic [1:0] beats_left_q;
    logic [1:0] off_q;
    logic [2:0] cs_idx_q;
    logic active_q;
    logic wr_q;
    logic [1:0] ps_q;
    logic [31:0] wdata_q;
    logic [31:0] rdata_q;
    logic [21:0] base_q;
    logic boot_ext_q;
    logic boot_first_q;
    logic reset_out_d1_q;
    logic [15:0] lane_out;
    logic lane_up;
    logic lane_lo;
    logic [2:0] dec_idx;
    logic [3:0] dec_code;
    logic dec_hit;
    logic [1:0] beats_need;
    logic [3:0] cfg_waits [NUM_CS];
    logic [1:0] cfg_ps [NUM_CS];
    logic wdog_expire;

    // Decode of chip-select window from the top address byte
    function automatic logic [3:0] cs_decode(input logic [7:0] top);
        if (top >= CS_BASE_CODE && top <= CS_LAST_CODE) begin
            cs_decode = {1'b1, 3'(top - CS_BASE_CODE)};
        end else begin
            cs_decode = 4'h0;
        end
    endfunction

    // Bus cycles needed after the first for a size on a port
    function automatic logic [1:0] beats_for(input logic [1:0] sz, input logic [1:0] ps);
        logic wide;
        wide = (ps == PS_16);
        case (sz)
            SZ_WORD: beats_for = wide ? 2'h1 : 2'h3;
            SZ_HALF: beats_for = wide ? 2'h0 : 2'h1;
            default: beats_for = 2'h0;
        endcase
    endfunction

    // Per-select config; select zero forced to reset values until configured
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CS; gi++) begin : g_cfg
            if (gi == 0) begin : g_zero
                assign cfg_waits[gi] = cfg_valid ? cs_wait_states[3:0] : CS0_RESET_WAITS;
                assign cfg_ps[gi] = cfg_valid ? port_size_field[1:0] : CS0_RESET_PORT;
            end else begin : g_rest
                assign cfg_waits[gi] = cs_wait_states[gi*4 +: 4];
                assign cfg_ps[gi] = port_size_field[gi*2 +: 2];
            end
        end
    endgenerate

    always_comb begin
        dec_code = cs_decode(core_addr[31:24]);
        dec_hit = dec_code[3];
        dec_idx = dec_code[2:0];
        beats_need = beats_for(core_size, cfg_ps[dec_idx]);
    end

    assign wdog_expire = active_q && (wdog_q == WDOG_LIMIT);

    eiu_lane_mux u_lane (
        .port_size(ps_q),
        .byte_off(off_q),
        .wdata(wdata_q),
        .ext_out(lane_out),
        .upper_en(lane_up),
        .lower_en(lane_lo)
    );

    // Boot source captured while reset-out is held
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            boot_ext_q <= 1'b0;
            boot_first_q <= 1'b0;
            reset_out_d1_q <= 1'b0;
        end else begin
            reset_out_d1_q <= reset_out_n;
            if (!reset_out_n) begin
                boot_ext_q <= ~boot_select;
                boot_first_q <= ~boot_select;
            end else if (core_req && state_q == EIU_IDLE && reset_out_d1_q) begin
                boot_first_q <= 1'b0;
            end
        end
    end

    assign int_rom_enable = ~boot_first_q;
    assign reset_vector = boot_ext_q ? BOOT_EXT_VECTOR : BOOT_INT_VECTOR;

    // Access sequencer
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_q <= EIU_IDLE;
            active_q <= 1'b0;
            wait_q <= 5'h00;
            beat_q <= 2'h0;
            beats_left_q <= 2'h0;
            off_q <= 2'h0;
            cs_idx_q <= 3'h0;
            wr_q <= 1'b0;
            ps_q <= PS_16;
            wdata_q <= 32'h0;
            rdata_q <= 32'h0;
            base_q <= 22'h0;
            transfer_size_code <= SZ_WORD;
        end else begin
            case (state_q)
                EIU_IDLE: begin
                    if (core_req && dec_hit && cs_enable[dec_idx]) begin
                        state_q <= EIU_CYCLE;
                        active_q <= 1'b1;
                        cs_idx_q <= dec_idx;
                        wr_q <= core_write;
                        ps_q <= cfg_ps[dec_idx];
                        wdata_q <= core_wdata;
                        base_q <= core_addr[21:0];
                        // Aligned start; low bits forced for halfword/word
                        off_q <= (core_size == SZ_WORD) ? 2'h0 :
                                 (core_size == SZ_HALF) ? {core_addr[1], 1'b0} : core_addr[1:0];
                        beats_left_q <= beats_need;
                        beat_q <= 2'h0;
                        // One setup cycle so the pins settle before the strobed edge
                        wait_q <= {1'b0, cfg_waits[dec_idx]} + 5'h01;
                        transfer_size_code <= core_size;
                    end
                end
                EIU_CYCLE: begin
                    if (wdog_expire) begin
                        state_q <= EIU_DONE;
                        active_q <= 1'b0;
                    end else if (wait_q != 5'h00) begin
                        wait_q <= wait_q - 5'h01;
                    end else begin
                        // Capture read data into the addressed byte(s)
                        if (ps_q == PS_16) begin
                            rdata_q[8*(3-{off_q[1], 1'b0}) +: 8] <= ext_data_in[15:8];
                            rdata_q[8*(3-{off_q[1], 1'b1}) +: 8] <= ext_data_in[7:0];
                        end else if (ps_q == PS_8_UPPER) begin
                            rdata_q[8*(3-off_q) +: 8] <= ext_data_in[15:8];
                        end else begin
                            rdata_q[8*(3-off_q) +: 8] <= ext_data_in[7:0];
                        end
                        if (beats_left_q == 2'h0) begin
                            state_q <= EIU_DONE;
                            active_q <= 1'b0;
                        end else begin
                            state_q <= EIU_NEXT;
                        end
                    end
                end
                EIU_NEXT: begin
                    beats_left_q <= beats_left_q - 2'h1;
                    beat_q <= beat_q + 2'h1;
                    off_q <= off_q + ((ps_q == PS_16) ? 2'h2 : 2'h1);
                    wait_q <= {1'b0, cfg_waits[cs_idx_q]} + 5'h01;
                    state_q <= wdog_expire ? EIU_DONE : EIU_CYCLE;
                    active_q <= ~wdog_expire;
                end
                EIU_DONE: begin
                    state_q <= EIU_IDLE;
                end
                default: begin
                    state_q <= EIU_IDLE;
                    active_q <= 1'b0;
                end
            endcase
        end
    end

    // Watchdog counts from access start, cleared each termination
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wdog_q <= 8'h0;
        end else if (!active_q) begin
            wdog_q <= 8'h0;
        end else begin
            wdog_q <= wdog_q + 8'h1;
        end
    end

    // Core answers
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            transfer_ack <= 1'b0;
            transfer_error_ack <= 1'b0;
            core_rdata <= 32'h0;
        end else begin
            transfer_ack <= (state_q == EIU_CYCLE) && !wdog_expire && wait_q == 5'h00
                && beats_left_q == 2'h0;
            transfer_error_ack <= wdog_expire;
            if (state_q == EIU_DONE) begin
                core_rdata <= rdata_q;
            end
        end
    end

    // External pins; address and data hold when idle
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ext_address_lines <= '0;
            ext_data_out <= '0;
        end else if (active_q && state_q == EIU_CYCLE) begin
            ext_address_lines <= {base_q[21:2], off_q};
            if (wr_q) begin
                ext_data_out <= (ps_q == PS_16 && !off_q[0]) ?
                    {lane_out[15:8], wdata_q[8*(2-off_q) +: 8]} : lane_out;
            end
        end
    end

    always_comb begin
        ext_data_oe = active_q && wr_q;
        rd_wr = ~(active_q && wr_q);
        out_enable_n = ~(active_q && !wr_q);
        // Both lanes on a 16-bit port for halfword and word beats
        byte_lane_enable_upper_n = ~(active_q && (lane_up || (ps_q == PS_16 && transfer_size_code != SZ_BYTE)));
        byte_lane_enable_lower_n = ~(active_q && (lane_lo || (ps_q == PS_16 && transfer_size_code != SZ_BYTE)));
        // Select zero active low; after boot from it, asserted on first fetch only if cs_enable[0] is set
        chip_select_zero_n = ~(active_q && cs_idx_q == 3'h0);
        for (int i = 0; i < 4; i++) begin
            // General outputs until enabled as selects
            chip_selects_one_to_four_n[i] = cs_enable[i+1] ?
                ~(active_q && cs_idx_q == 3'(i + 1)) : (cfg_valid ? cs_gpo_level[i+1] : 1'b1);
        end
        chip_select_five_high = cs_enable[5] ?
            (active_q && cs_idx_q == 3'h5) : (cfg_valid && cs_gpo_level[5]);
    end
endmodule
`default_nettype wire

// [design/eiu_lane_mux.sv]
// Byte lane steering between the internal word and the external port
`timescale 1ns/10ps
`default_nettype none
module eiu_lane_mux
    import eiu_pkg::*;
(
    input wire logic [1:0] port_size,
    input wire logic [1:0] byte_off,
    input wire logic [31:0] wdata,
    output logic [15:0] ext_out,
    output logic upper_en,
    output logic lower_en
);
    logic [7:0] sel_byte;

    always_comb begin
        // Offset 0 is the top byte of the internal word
        case (byte_off)
            2'h0: sel_byte = wdata[31:24];
            2'h1: sel_byte = wdata[23:16];
            2'h2: sel_byte = wdata[15:8];
            default: sel_byte = wdata[7:0];
        endcase
        ext_out = {sel_byte, sel_byte};
        upper_en = 1'b0;
        lower_en = 1'b0;
        case (port_size)
            PS_8_UPPER: upper_en = 1'b1;
            PS_8_LOWER: lower_en = 1'b1;
            default: begin
                // Even bytes high lane, odd bytes low lane
                upper_en = ~byte_off[0];
                lower_en = byte_off[0];
            end
        endcase
    end
endmodule
`default_nettype wire

// [shared/eiu_pkg.sv]
// Constants and types for the external interface unit
package eiu_pkg;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int NUM_CS = 6;
    localparam logic [7:0] CS_BASE_CODE = 8'h40;
    localparam logic [7:0] CS_LAST_CODE = 8'h45;
    localparam logic [31:0] BOOT_EXT_VECTOR = 32'h4000_0000;
    localparam logic [31:0] BOOT_INT_VECTOR = 32'h0000_0000;
    // Port-size field encodings
    localparam logic [1:0] PS_8_UPPER = 2'h0;
    localparam logic [1:0] PS_8_LOWER = 2'h1;
    localparam logic [1:0] PS_16 = 2'h2;
    // Transfer size code
    localparam logic [1:0] SZ_WORD = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_HALF = 2'h2;
    // Reset values for chip select zero
    localparam logic [3:0] CS0_RESET_WAITS = 4'hf;
    localparam logic [1:0] CS0_RESET_PORT = PS_16;
    // Watchdog limit
    localparam int WDOG_CYCLES = 128;
    localparam logic [7:0] WDOG_LIMIT = 8'(WDOG_CYCLES - 1);
    typedef enum logic [3:0] {
        EIU_IDLE = 4'b0001,
        EIU_CYCLE = 4'b0010,
        EIU_NEXT = 4'b0100,
        EIU_DONE = 4'b1000
    } eiu_state_t;
endpackage

// [verification/eiu_chk.sv]
// Concurrent checks on the external interface unit ports
`timescale 1ns/10ps
`default_nettype none
module eiu_chk
    import eiu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic core_req,
    input wire logic [31:0] core_addr,
    input wire logic [1:0] core_size,
    input wire logic transfer_ack,
    input wire logic transfer_error_ack,
    input wire logic [1:0] transfer_size_code,
    input wire logic [eiu_pkg::NUM_CS-1:0] cs_enable,
    input wire logic [eiu_pkg::ADDR_W-1:0] ext_address_lines,
    input wire logic ext_data_oe,
    input wire logic rd_wr,
    input wire logic out_enable_n,
    input wire logic chip_select_zero_n,
    input wire logic chip_select_five_high
);
    logic [8:0] busy_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Cycles a request has waited for its answer
    always_ff @(posedge clk_sys) begin
        if (!rstn || !core_req || transfer_ack || transfer_error_ack) begin
            busy_q <= 9'h000;
        end else begin
            busy_q <= busy_q + 9'h001;
        end
    end
    sequence s_quiet;
        !transfer_ack && !transfer_error_ack;
    endsequence
    AST_READ_STROBE: assert property (!out_enable_n |-> rd_wr && !ext_data_oe)
        else $error("output enable low outside a read");
    AST_ADDR_HOLD: assert property (!core_req && $past(!core_req) |-> $stable(ext_address_lines))
        else $error("address moved while idle");
    AST_CS0_DECODE: assert property (!chip_select_zero_n |-> core_addr[31:24] == CS_BASE_CODE)
        else $error("select zero outside its window");
    AST_CS5_DECODE: assert property (chip_select_five_high && cs_enable[5] |-> core_addr[31:24] == CS_LAST_CODE)
        else $error("select five outside its window");
    AST_ACK_ONCE: assert property (transfer_ack |=> s_quiet)
        else $error("acknowledge longer than one cycle");
    AST_ACK_CAUSE: assert property (transfer_ack |-> $past(core_req))
        else $error("acknowledge without request");
    AST_ACK_EXCL: assert property (!(transfer_ack && transfer_error_ack))
        else $error("both acknowledges at once");
    AST_WDOG_BOUND: assert property (busy_q <= 9'h082)
        else $error("access outlived the watchdog");
    AST_WDOG_ERR: assert property (transfer_error_ack |-> busy_q >= 9'h07e && out_enable_n && rd_wr)
        else $error("error acknowledge at wrong time");
    AST_SIZE_CODE: assert property (transfer_ack |-> transfer_size_code == core_size)
        else $error("size code differs from request");
endmodule
`default_nettype wire

// [verification/eiu_mem_model.sv]
// Behavioural memory on the external data bus
`timescale 1ns/10ps
`default_nettype none
module eiu_mem_model (
    input wire logic clk_sys,
    input wire logic [21:0] addr,
    input wire logic upper_n,
    input wire logic lower_n,
    input wire logic oe_n,
    input wire logic rd_wr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata
);
    logic [7:0] up [256];
    logic [7:0] lo [256];
    logic [15:0] last_q = 16'h0000;
    // Released bus toggles, never shows a stale value
    assign rdata = !oe_n ? {up[addr[7:0]], lo[addr[7:0]]} : ~last_q;
    always @(posedge clk_sys) begin
        last_q <= rdata;
        if (!rd_wr && !upper_n) up[addr[7:0]] <= wdata[15:8];
        if (!rd_wr && !lower_n) lo[addr[7:0]] <= wdata[7:0];
    end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking testbench for the external interface unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
    import eiu_pkg::*;
    logic clk_sys = 0, rstn = 0, core_req = 0, core_write = 0, cfg_valid = 0, boot_select = 0, reset_out_n = 0;
    logic [31:0] core_addr = 0, core_wdata = 0, core_rdata, reset_vector, rd, d;
    logic [1:0] core_size = 0, transfer_size_code, ps;
    logic [5:0] cs_enable = 6'h3f, cs_gpo_level = 6'h00;
    logic [23:0] cs_wait_states = 24'h000000;
    logic [11:0] port_size_field = 12'ha91;
    logic transfer_ack, transfer_error_ack, int_rom_enable, ext_data_oe, rd_wr, up_n, lo_n, oe_n, cs0_n, cs5;
    logic [3:0] cs14_n;
    logic [21:0] ext_address_lines;
    logic [15:0] d_in, d_out;
    int mismatches = 0, n_tests = 0, cycles = 0, cyc;
    always #20 clk_sys = ~clk_sys;
    eiu_external_interface_unit eiu_external_interface_unit_inst (.clk_sys(clk_sys), .rstn(rstn),
        .core_req(core_req), .core_write(core_write), .core_addr(core_addr), .core_size_unused(12'h000),
        .core_size(core_size), .core_wdata(core_wdata), .core_rdata(core_rdata), .transfer_ack(transfer_ack),
        .transfer_error_ack(transfer_error_ack), .transfer_size_code(transfer_size_code), .cs_enable(cs_enable),
        .cs_gpo_level(cs_gpo_level), .cs_wait_states(cs_wait_states), .port_size_field(port_size_field),
        .cfg_valid(cfg_valid), .boot_select(boot_select), .reset_out_n(reset_out_n),
        .int_rom_enable(int_rom_enable), .reset_vector(reset_vector), .ext_address_lines(ext_address_lines),
        .ext_data_in(d_in), .ext_data_out(d_out), .ext_data_oe(ext_data_oe), .rd_wr(rd_wr),
        .byte_lane_enable_upper_n(up_n), .byte_lane_enable_lower_n(lo_n), .out_enable_n(oe_n),
        .chip_select_zero_n(cs0_n), .chip_selects_one_to_four_n(cs14_n), .chip_select_five_high(cs5));
    eiu_mem_model m (.clk_sys(clk_sys), .addr(ext_address_lines), .upper_n(up_n), .lower_n(lo_n),
        .oe_n(oe_n), .rd_wr(rd_wr), .wdata(d_out), .rdata(d_in));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    // One access, request held until acknowledged or limit reached
    task automatic acc(input logic w, input logic [31:0] a, input logic [1:0] sz, input logic [31:0] dv, input int lim);
        cyc = 0;
        core_write = w;
        core_addr = a;
        core_size = sz;
        core_wdata = dv;
        core_req = 1'b1;
        while (cyc < lim && transfer_ack !== 1'b1) begin
            @(negedge clk_sys);
            cyc++;
        end
        core_req = 1'b0;
        @(negedge clk_sys);
        rd = core_rdata;
    endtask
    // Bytes seen by the memory against big-endian lane placement
    task automatic chk_lay(input logic [1:0] p, input logic [7:0] off, input int n, input logic [31:0] dv);
        logic [7:0] o;
        for (int k = 0; k < n; k++) begin
            o = off + 8'(k);
            if (p == PS_16) `CHK(o[0] ? m.lo[o & 8'hfe] : m.up[o & 8'hfe], dv[8 * (3 - o[1:0]) +: 8])
            else `CHK(p == PS_8_UPPER ? m.up[o] : m.lo[o], dv[8 * (3 - o[1:0]) +: 8])
        end
    endtask
    task automatic reboot(input logic b);
        rstn = 0;
        reset_out_n = 0;
        boot_select = b;
        repeat (10) @(negedge clk_sys);
        rstn = 1;
        repeat (6) @(negedge clk_sys);
        reset_out_n = 1;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic t_cs0();
        `CHK(reset_vector, BOOT_EXT_VECTOR)
        `CHK(int_rom_enable, 1'b0)
        `CHK({cs14_n, cs5, cs0_n, rd_wr, oe_n}, 8'hf7)
        acc(1'b1, 32'h4000_0000, SZ_WORD, 32'h1122_3344, 100);
        `CHK(cyc >= 30 && cyc <= 40, 1'b1)
        chk_lay(PS_16, 8'h00, 4, 32'h1122_3344);
        `CHK(int_rom_enable, 1'b1)
        $display("test cs0 done");
    endtask
    task automatic t_gpo();
        cfg_valid = 1;
        port_size_field = 12'ha92;
        cs_enable = 6'h01;
        cs_gpo_level = 6'b101010;
        repeat (2) @(negedge clk_sys);
        `CHK(cs14_n, 4'b0101)
        `CHK(cs5, 1'b1)
        cs_enable = 6'h3f;
        repeat (2) @(negedge clk_sys);
        `CHK({cs14_n, cs5}, 5'h1e)
        $display("test gpo done");
    endtask
    task automatic t_sizes();
        for (int i = 1; i < 6; i++) begin
            ps = port_size_field[2 * i +: 2];
            d = 32'h1234_5678 ^ 32'(i);
            acc(1'b1, {8'h40 + 8'(i), 24'h000010}, SZ_WORD, d, 100);
            chk_lay(ps, 8'h10, 4, d);
            acc(1'b0, {8'h40 + 8'(i), 24'h000010}, SZ_WORD, 32'h0, 100);
            `CHK(rd, d)
        end
        acc(1'b1, 32'h4300_0022, SZ_HALF, 32'h0000_5566, 100);
        chk_lay(PS_16, 8'h22, 2, 32'h0000_5566);
        acc(1'b0, 32'h4300_0022, SZ_HALF, 32'h0, 100);
        `CHK(rd[15:0], 16'h5566)
        acc(1'b1, 32'h4300_0031, SZ_BYTE, 32'h0077_0000, 100);
        acc(1'b0, 32'h4300_0031, SZ_BYTE, 32'h0, 100);
        `CHK(rd[23:16], 8'h77)
        `CHK(m.lo[8'h30] === 8'h77 || m.lo[8'h31] === 8'h77, 1'b1)
        $display("test sizes done");
    endtask
    task automatic t_misc();
        acc(1'b1, 32'h4140_0005, SZ_BYTE, 32'h00ab_0000, 100);
        `CHK(m.up[8'h05], 8'hab)
        acc(1'b0, 32'h4600_0000, SZ_WORD, 32'h0, 20);
        `CHK(cyc, 20)
        cs_enable = 6'h2f;
        acc(1'b0, 32'h4400_0000, SZ_WORD, 32'h0, 20);
        `CHK(cyc, 20)
        cs_enable = 6'h3f;
        `CHK(ext_address_lines, 22'h000005)
        $display("test misc done");
    endtask
    initial begin
        reboot(1'b0);
        t_cs0();
        t_gpo();
        t_sizes();
        t_misc();
        reboot(1'b1);
        `CHK({reset_vector, int_rom_enable}, {BOOT_INT_VECTOR, 1'b1})
        $display("test boot done");
        give_verdict();
    end
endmodule
bind eiu_external_interface_unit eiu_chk eiu_chk_inst (.clk_sys, .rstn, .core_req, .core_addr, .core_size,
    .transfer_ack, .transfer_error_ack, .transfer_size_code, .cs_enable, .ext_address_lines, .ext_data_oe,
    .rd_wr, .out_enable_n, .chip_select_zero_n, .chip_select_five_high);
`default_nettype wire
